// File: logic/rps_pkg.sv
// constants and state codes for the reset pin control block
// assumes a single 50 MHz system clock with synchronous active-high reset
package rps_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CS_W   = 11;
  localparam int unsigned MOD_W  = 8;

  // ****************************************************
  // timing, in system clock output cycles except the half period
  // ****************************************************
  localparam logic [9:0] STRETCH_TICKS   = 10'h200;
  localparam logic [9:0] FLOAT_TICKS     = 10'h00A;
  localparam logic [9:0] FIRST_BUS_TICKS = 10'h00A;
  // system clock output half period, in system clock cycles
  localparam logic [3:0] SYSTEM_CLOCK_OUTPUT_HALF     = 4'h1;

  // ****************************************************
  // reset values and field positions
  // ****************************************************
  localparam logic              BOOT_CS_NEGATED = 1'b1;
  localparam logic [CS_W-1:0]   CS_NEGATED      = 11'h7FF;
  localparam logic [DATA_W-1:0] MODE_DEFAULT    = 16'hFFFF;
  localparam int unsigned       MODE_BOOT_BIT   = 0;

  // ****************************************************
  // sequencer states
  // ****************************************************
  typedef enum logic [5:0] {
    S_EXT     = 6'h01,
    S_STRETCH = 6'h02,
    S_FLOAT   = 6'h04,
    S_MODE    = 6'h08,
    S_EXC     = 6'h10,
    S_RUN     = 6'h20
  } rps_seq_t;

endpackage

// File: logic/rps_reset_pin_ctrl.sv
// reset pin sequencer and pin state control of the system integration unit
// assumes reset and data pins arrive asynchronously; int_reset_req_i is
// on clk_sys_i; the open-drain reset pin is resolved outside
`timescale 1ns/1ns
`default_nettype none
//  Contract
// - reset returns module pins to port inputs
// - clear alternate functions and direction registers
// - unit pins float or drive inactive
// - mode selection precedes reset exception processing
// - outputs start functioning only after release
// - driver state independent of pin function
// - low data lines select alternate configuration
// - first bus cycle ten clock-outs later
// - hold reset pin 512 clock-outs more
module rps_reset_pin_ctrl (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic                        reset_pin_i,
  input  wire logic                        int_reset_req_i,
  input  wire logic [rps_pkg::DATA_W-1:0]  data_pin_i,
  output logic                             reset_pin_o,
  output logic                             reset_pin_oe_o,
  output logic                             system_clock_output_o,
  output logic [rps_pkg::MOD_W-1:0]        alt_fn_en_o,
  output logic [rps_pkg::MOD_W-1:0]        port_dir_o,
  output logic                             sim_pin_oe_o,
  output logic [rps_pkg::CS_W-1:0]         cs_n_o,
  output logic                             boot_cs_n_o,
  output logic                             boot_port_8bit_o,
  output logic [rps_pkg::DATA_W-1:0]       mode_word_o,
  output logic                             out_en_o,
  output logic                             exc_start_o,
  output logic                             bus_start_o
);
  import rps_pkg::*;

  // ****************************************************
  // state record
  // ****************************************************
  typedef struct packed {
    logic              rst_meta;
    logic              rst_sync;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    rps_seq_t          st;
    logic [9:0]        cnt;
    logic              pin_oe;
    logic              in_rst;
    logic              sim_oe;
    logic              boot_cs_n;
    logic              boot8;
    logic [DATA_W-1:0] mode;
    logic              exc_start;
    logic              bus_start;
  } rps_ctrl_t;

  rps_ctrl_t s_q;
  rps_ctrl_t s_d;
  logic      tick;

  rps_system_clock_output_div u_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .system_clock_output_o  (system_clock_output_o),
    .tick_o    (tick)
  );

  // ****************************************************
  // sequencer
  // ****************************************************
  always_comb begin
    s_d           = s_q;
    s_d.rst_meta  = reset_pin_i;
    s_d.rst_sync  = s_q.rst_meta;
    s_d.data_meta = data_pin_i;
    s_d.data_sync = s_q.data_meta;
    s_d.exc_start = 1'b0;
    s_d.bus_start = 1'b0;
    unique case (s_q.st)
      S_EXT: begin
        // external source holds the pin; stretch once it lets go
        if (s_q.rst_sync) begin
          s_d.st  = S_STRETCH;
          s_d.cnt = STRETCH_TICKS;
        end
      end
      S_STRETCH: begin
        if (tick) begin
          if (s_q.cnt == 10'h001) begin
            if (!int_reset_req_i) begin
              s_d.st  = S_FLOAT;
              s_d.cnt = FLOAT_TICKS;
            end
          end else begin
            s_d.cnt = s_q.cnt - 10'h001;
          end
        end
      end
      S_FLOAT: begin
        if (tick) begin
          if (s_q.cnt == 10'h001) begin
            if (s_q.rst_sync) begin
              s_d.st = S_MODE;
            end else begin
              s_d.st  = S_STRETCH;
              s_d.cnt = STRETCH_TICKS;
            end
          end else begin
            s_d.cnt = s_q.cnt - 10'h001;
          end
        end
      end
      S_MODE: begin
        s_d.mode      = s_q.data_sync;
        s_d.boot8     = ~s_q.data_sync[MODE_BOOT_BIT];
        s_d.st        = S_EXC;
        s_d.cnt       = FIRST_BUS_TICKS;
        s_d.exc_start = 1'b1;
      end
      S_EXC: begin
        if (tick) begin
          if (s_q.cnt == 10'h001) begin
            s_d.st        = S_RUN;
            s_d.bus_start = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - 10'h001;
          end
        end
      end
      S_RUN: begin
        if (int_reset_req_i) begin
          s_d.st  = S_STRETCH;
          s_d.cnt = STRETCH_TICKS;
        end else if (!s_q.rst_sync) begin
          s_d.st = S_EXT;
        end
      end
      default: begin
        s_d.st  = S_STRETCH;
        s_d.cnt = STRETCH_TICKS;
      end
    endcase
    // outputs follow the next state so they leave flip-flops directly
    s_d.pin_oe    = (s_d.st == S_STRETCH);
    s_d.in_rst    = !(s_d.st == S_EXC || s_d.st == S_RUN);
    s_d.sim_oe    = !s_d.in_rst;
    s_d.boot_cs_n = s_d.in_rst;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '{rst_meta: 1'b0, rst_sync: 1'b0,
               data_meta: MODE_DEFAULT, data_sync: MODE_DEFAULT,
               st: S_STRETCH, cnt: STRETCH_TICKS, pin_oe: 1'b1,
               in_rst: 1'b1, sim_oe: 1'b0, boot_cs_n: BOOT_CS_NEGATED,
               boot8: 1'b0, mode: MODE_DEFAULT, exc_start: 1'b0,
               bus_start: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // pin outputs
  // ****************************************************
  assign reset_pin_o      = 1'b0;
  assign reset_pin_oe_o   = s_q.pin_oe;
  assign alt_fn_en_o      = {MOD_W{s_q.sim_oe}};
  assign port_dir_o       = {MOD_W{s_q.sim_oe}};
  assign sim_pin_oe_o     = s_q.sim_oe;
  assign cs_n_o           = CS_NEGATED;
  assign boot_cs_n_o      = s_q.boot_cs_n;
  assign boot_port_8bit_o = s_q.boot8;
  assign mode_word_o      = s_q.mode;
  assign out_en_o         = s_q.sim_oe;
  assign exc_start_o      = s_q.exc_start;
  assign bus_start_o      = s_q.bus_start;

  // ****************************************************
  // checks
  // ****************************************************
  logic [10:0] hold_cyc;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !reset_pin_oe_o) begin
      hold_cyc <= 11'h000;
    end else if (hold_cyc != 11'h7FF) begin
      hold_cyc <= hold_cyc + 11'h001;
    end
  end

  port_default_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(reset_pin_oe_o) |-> (alt_fn_en_o == '0) && (port_dir_o == '0))
    else $error("module pins not returned to port inputs");
  dir_cleared_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_q.st == S_FLOAT) |-> (port_dir_o == '0) && (alt_fn_en_o == '0))
    else $error("direction or function not cleared in reset");
  unit_pins_idle_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reset_pin_oe_o |-> !sim_pin_oe_o && (cs_n_o == CS_NEGATED))
    else $error("unit pin driven active during reset");
  mode_first_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      exc_start_o |-> $past(s_q.st == S_MODE) && $changed(s_q.st))
    else $error("exception start not preceded by mode selection");
  outputs_late_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(out_en_o) |-> exc_start_o)
    else $error("outputs enabled before release");
  drive_indep_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $changed(mode_word_o) |-> $past(!sim_pin_oe_o))
    else $error("pin driver tied to function change");
  mode_latch_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_q.st == S_MODE) |=> (mode_word_o == $past(s_q.data_sync)))
    else $error("mode word not latched from data lines");
  first_bus_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      exc_start_o && !int_reset_req_i |->
        ##[18:21] (bus_start_o || int_reset_req_i))
    else $error("first bus cycle not ten clock-outs after release");
  stretch_len_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(reset_pin_oe_o) |-> ($past(hold_cyc) >= 11'h3FC))
    else $error("reset pin released before 512 clock-outs");
  boot_cs_a:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      bus_start_o |-> !boot_cs_n_o && (cs_n_o == CS_NEGATED)
        && $past(!boot_cs_n_o, 18))
    else $error("boot chip-select not asserted after release");

endmodule
`default_nettype wire

// File: logic/rps_system_clock_output_div.sv
// system clock output divider: pin level and one-cycle rising-edge tick
// assumes clk_sys_i is the only clock; rst_i is synchronous
`timescale 1ns/1ns
`default_nettype none
module rps_system_clock_output_div (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  output logic      system_clock_output_o,
  output logic      tick_o
);
  import rps_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       lvl;
    logic       tick;
  } rps_div_t;

  rps_div_t s_q;
  rps_div_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 4'h1) begin
      s_d.cnt  = SYSTEM_CLOCK_OUTPUT_HALF;
      s_d.lvl  = ~s_q.lvl;
      s_d.tick = ~s_q.lvl;
    end else begin
      s_d.cnt = s_q.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '{cnt: SYSTEM_CLOCK_OUTPUT_HALF, lvl: 1'b0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign system_clock_output_o = s_q.lvl;
  assign tick_o   = s_q.tick;

endmodule
`default_nettype wire

// File: testbench/rps_board.sv
// board model: open-drain reset wire and mode-select drivers
// assumes the device side only pulls the reset wire low
`timescale 1ns/1ns
`default_nettype none
module rps_board (
  input  wire logic        clk_sys_i,
  input  wire logic        pin_oe_i,
  input  wire logic        ext_low_i,
  input  wire logic        exc_i,
  input  wire logic [15:0] mask_i,
  output logic             reset_pin_o,
  output logic [15:0]      data_o
);
  logic drv_q = 1'b0;
  // ****
  // wire resolution and drivers
  // ****
  // pull-up on reset wire
  assign reset_pin_o = !(pin_oe_i || ext_low_i);
  always_ff @(posedge clk_sys_i) begin
    if (!reset_pin_o)
      drv_q <= 1'b1;
    else if (exc_i)
      drv_q <= 1'b0;
  end
  assign data_o = drv_q ? ~mask_i : 16'hFFFF;
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the reset pin control block
// assumes rps_board models the pins around the device
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t value differs", $time); end end
module tb;
  import rps_pkg::*;
  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] mode;
    logic        boot8;
  } rps_row_t;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        int_req   = 1'b0;
  logic        ext_low   = 1'b0;
  logic [15:0] mask      = 16'h0000;
  logic        pin_w, pin_oe, clk_out, unit_oe, boot_cs_n, boot8;
  logic        out_en, exc, bus, pin_lvl;
  logic [7:0]  alt_fn, port_dir;
  logic [10:0] cs_n;
  logic [15:0] data_w, mode_word;
  int          failures  = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  int          n;
  rps_row_t    rows [4]  = '{'{16'h0000, 16'hFFFF, 1'b0},
    '{16'h0001, 16'hFFFE, 1'b1}, '{16'h0106, 16'hFEF9, 1'b0},
    '{16'h00F8, 16'hFF07, 1'b0}};
  rps_reset_pin_ctrl rps_reset_pin_ctrl_i (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .reset_pin_i(pin_w), .int_reset_req_i(int_req),
    .data_pin_i(data_w), .reset_pin_o(pin_lvl), .reset_pin_oe_o(pin_oe),
    .system_clock_output_o(clk_out), .alt_fn_en_o(alt_fn), .port_dir_o(port_dir),
    .sim_pin_oe_o(unit_oe), .cs_n_o(cs_n), .boot_cs_n_o(boot_cs_n),
    .boot_port_8bit_o(boot8), .mode_word_o(mode_word),
    .out_en_o(out_en), .exc_start_o(exc), .bus_start_o(bus));
  rps_board rps_board_i (.clk_sys_i(clk_sys_i), .pin_oe_i(pin_oe),
    .ext_low_i(ext_low), .exc_i(exc), .mask_i(mask),
    .reset_pin_o(pin_w), .data_o(data_w));
  // ****
  // clock, timeout and shared tasks
  // ****
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  // selects the watched signal: 0 exception start, 1 first bus, 2 pin drive
  function automatic logic pick(input int k);
    case (k)
      0: return exc;
      1: return bus;
      default: return pin_oe;
    endcase
  endfunction
  task automatic wait_lvl(input int k, input logic lvl, input int lim,
                          output int c);
    c = 0;
    while (pick(k) !== lvl && c < lim) begin
      tick();
      c++;
    end
  endtask
  task automatic after_exc(input rps_row_t r);
    logic co;
    wait_lvl(0, 1'b1, 1200, n);
    `CHK(exc, 1'b1)
    `CHK(mode_word, r.mode)
    `CHK(boot8, r.boot8)
    `CHK(boot_cs_n, 1'b0)
    `CHK(alt_fn, 8'hFF)
    `CHK(out_en, 1'b1)
    `CHK(cs_n, CS_NEGATED)
    `CHK(port_dir, 8'hFF)
    co = clk_out;
    tick();
    `CHK(exc, 1'b0)
    `CHK(clk_out, ~co)
    wait_lvl(1, 1'b1, 40, n);
    `CHK(n >= 16 && n <= 21, 1'b1)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (5) tick();
    `CHK(pin_oe, 1'b1)
    `CHK(boot_cs_n, BOOT_CS_NEGATED)
    `CHK(mode_word, MODE_DEFAULT)
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    after_exc(rows[0]);
    $display("test power-up done");
    foreach (rows[i]) begin
      @(posedge clk_sys_i);
      mask    <= rows[i].mask;
      int_req <= 1'b1;
      @(posedge clk_sys_i);
      int_req <= 1'b0;
      #1;
      wait_lvl(2, 1'b1, 8, n);
      `CHK(alt_fn, 8'h00)
      `CHK(port_dir, 8'h00)
      `CHK(unit_oe, 1'b0)
      `CHK(out_en, 1'b0)
      `CHK(boot_cs_n, 1'b1)
      `CHK(pin_lvl, 1'b0)
      wait_lvl(2, 1'b0, 1100, n);
      `CHK(n >= 1016 && n <= 1028, 1'b1)
      `CHK(unit_oe, 1'b0)
      after_exc(rows[i]);
      $display("test row %0d done", i);
    end
    @(posedge clk_sys_i);
    ext_low <= 1'b1;
    repeat (4) tick();
    `CHK(pin_oe, 1'b0)
    `CHK(unit_oe, 1'b0)
    `CHK(port_dir, 8'h00)
    @(posedge clk_sys_i);
    ext_low <= 1'b0;
    #1;
    wait_lvl(2, 1'b1, 8, n);
    @(posedge clk_sys_i);
    ext_low <= 1'b1;
    #1;
    wait_lvl(2, 1'b0, 1100, n);
    wait_lvl(2, 1'b1, 40, n);
    `CHK(pin_oe, 1'b1)
    `CHK(out_en, 1'b0)
    @(posedge clk_sys_i);
    ext_low <= 1'b0;
    #1;
    after_exc(rows[3]);
    $display("test external hold done");
    report_and_stop();
  end
endmodule
`default_nettype wire
